// ---- hw/tcad_pkg.sv ----
// Constants for the transmit command word A decoder.
// Assumes 32-bit words arrive in host write order: command A, command B, then payload.
package tcad_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned BE_W = 4;
  // Command A field positions
  localparam int unsigned CMDA_IRQ_BIT = 31;
  localparam int unsigned CMDA_ALIGN_HI = 25;
  localparam int unsigned CMDA_ALIGN_LO = 24;
  localparam int unsigned CMDA_OFF_HI = 20;
  localparam int unsigned CMDA_OFF_LO = 16;
  localparam int unsigned CMDA_FS_BIT = 13;
  localparam int unsigned CMDA_LS_BIT = 12;
  localparam int unsigned CMDA_SIZE_HI = 10;
  localparam int unsigned CMDA_SIZE_LO = 0;
  localparam int unsigned OFF_W = 5;
  localparam int unsigned SIZE_W = 11;
  localparam int unsigned END_W = 12;
  localparam int unsigned NW_W = 10;
  localparam int unsigned IDX_W = 11;
  // Buffer end alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSVD = 2'h3;
  // Word count masks for rounding up to the alignment
  localparam logic [NW_W-1:0] AMASK_4 = 10'h000;
  localparam logic [NW_W-1:0] AMASK_16 = 10'h003;
  localparam logic [NW_W-1:0] AMASK_32 = 10'h007;
  // Reset values
  localparam logic [OFF_W-1:0] OFF_RST = 5'h00;
  localparam logic [SIZE_W-1:0] SIZE_RST = 11'h000;
  localparam logic [IDX_W-1:0] IDX_RST = 11'h000;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned ENTRY_W = WORD_W + BE_W + 3;
  typedef enum logic [1:0] {
    TCAD_CMD_A,
    TCAD_CMD_B,
    TCAD_DATA
  } tcad_state_t;
endpackage

// ---- hw/tcad_word_if.sv ----
// Payload word carrier between the decoder and its two-entry buffer.
// Assumes both ends share clk_sys_i.
interface tcad_word_if;
  logic [tcad_pkg::WORD_W-1:0] data;
  logic [tcad_pkg::BE_W-1:0] be;
  logic first_seg;
  logic last_seg;
  logic buf_end;
  logic valid;
  logic ready;
  modport src (output data, output be, output first_seg, output last_seg,
               output buf_end, output valid, input ready);
  modport snk (input data, input be, input first_seg, input last_seg,
               input buf_end, input valid, output ready);
endinterface

// ---- hw/tcad_skid.sv ----
// Two-entry payload buffer so that a stall by the receiver loses no word.
// Assumes a single clock and synchronous active-low reset.
module tcad_skid (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  tcad_word_if.snk wr_if,
  tcad_word_if.src rd_if
);
  logic [tcad_pkg::ENTRY_W-1:0] mem_reg [tcad_pkg::BUF_DEPTH];
  logic [tcad_pkg::ENTRY_W-1:0] mem_next [tcad_pkg::BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign wr_if.ready = (cnt_reg != 2'h2);
  assign rd_if.valid = (cnt_reg != 2'h0);
  assign push = wr_if.valid && wr_if.ready;
  assign pop = rd_if.valid && rd_if.ready;
  assign {rd_if.buf_end, rd_if.last_seg, rd_if.first_seg, rd_if.be, rd_if.data} =
    mem_reg[rd_ptr_reg];

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = {wr_if.buf_end, wr_if.last_seg, wr_if.first_seg,
                              wr_if.be, wr_if.data};
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
    end
  end
endmodule // tcad_skid

// ---- hw/tcad_decoder.sv ----
// Transmit command word A decoder with offset skip and end padding removal.
// Assumes the host writes command A, command B, then the buffer words, 32 bits each.
// How it works
// (R1) Bit 31 set: pulse buffer-loaded flag when the buffer's last word is taken.
// (R2) Buffer-loaded flag also goes to an interrupt output when routing is enabled.
// (R3) Host writes zeros into bits 30:26 and 23:21; they are ignored.
// (R4) Bits 25:24 pick end alignment: 4, 16 or 32 bytes; 11 reserved.
// (R5) Host pads the buffer with whole words up to the chosen alignment.
// (R6) Padding words after the payload are taken and dropped, never passed on.
// (R7) Bits 20:16 give first data byte offset, any value 0 to 31.
// (R8) Bytes before the start offset are dropped; wholly skipped words are not passed.
// (R9) Byte count in bits 10:0 with alignment sets how many pad words to drop.
// (R10) Bit 13 marks first segment, bit 12 marks last segment of a packet.
// (R11) Reserved alignment code acts as 4-byte alignment, so no pad words are dropped.
module tcad_decoder (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output logic [31:0] pay_data_o,
  output logic [3:0] pay_be_o,
  output logic pay_first_seg_o,
  output logic pay_last_seg_o,
  output logic pay_buf_end_o,
  output logic pay_valid_o,
  input wire logic pay_ready_i,
  input wire logic irq_route_en_i,
  output logic buffer_loaded_flag_o,
  output logic buffer_loaded_irq_o,
  output logic first_segment_bit_o,
  output logic last_segment_bit_o,
  output logic [1:0] align_code_o,
  output logic [4:0] start_offset_o,
  output logic [10:0] byte_count_o,
  output logic pad_drop_o
);
  // Command A fields are held until the next command A is taken
  tcad_pkg::tcad_state_t state_reg, state_next;
  logic irq_req_reg, irq_req_next;
  logic [1:0] align_reg, align_next;
  logic [tcad_pkg::OFF_W-1:0] off_reg, off_next;
  logic [tcad_pkg::SIZE_W-1:0] size_reg, size_next;
  logic fs_reg, fs_next, ls_reg, ls_next;
  logic [tcad_pkg::IDX_W-1:0] idx_reg, idx_next;
  logic done_reg, done_next, irq_reg, irq_next, pad_reg, pad_next;

  // Geometry of the buffer in progress, in bytes or in 32-bit words
  logic [tcad_pkg::END_W-1:0] end_byte;
  logic [tcad_pkg::END_W-1:0] end_plus;
  logic [tcad_pkg::NW_W-1:0] n_words;
  logic [tcad_pkg::NW_W-1:0] amask;
  logic [tcad_pkg::IDX_W-1:0] p_words;
  logic [tcad_pkg::IDX_W-1:0] n_ext;
  logic [tcad_pkg::BE_W-1:0] be_w;
  logic is_pad, emit, last_word, take;

  tcad_word_if wr_if ();
  tcad_word_if rd_if ();

  // Byte count excludes offset and padding, so the payload ends at offset plus count
  assign end_byte = {7'h00, off_reg} + {1'b0, size_reg}; // R9
  assign end_plus = end_byte + 12'h003;
  assign n_words = end_plus[11:2];
  assign n_ext = {1'b0, n_words};

  always_comb begin
    // Masks round the word count up to a whole burst of 1, 4 or 8 words
    case (align_reg) // R4
      tcad_pkg::ALIGN_4: amask = tcad_pkg::AMASK_4;
      tcad_pkg::ALIGN_16: amask = tcad_pkg::AMASK_16;
      tcad_pkg::ALIGN_32: amask = tcad_pkg::AMASK_32;
      default: amask = tcad_pkg::AMASK_4; // R11
    endcase
  end

  // Total words the host writes, payload rounded up to the alignment
  assign p_words = (n_ext + {1'b0, amask}) & ~{1'b0, amask}; // R9

  // One byte lane each: valid from the start offset up to the payload end
  for (genvar b = 0; b < tcad_pkg::BE_W; b++) begin : g_lane
    logic [12:0] pos;
    assign pos = {idx_reg[10:0], 2'b00} + 13'(b);
    assign be_w[b] = (pos >= {8'h00, off_reg}) && (pos < {1'b0, end_byte}); // R8
  end

  // A word index past the payload can only be host padding
  assign is_pad = (idx_reg >= n_ext); // R6
  // Leading words with no valid lane are dropped just like padding
  assign emit = !is_pad && (be_w != 4'h0); // R8
  assign last_word = (idx_reg == (p_words - 11'h001));

  // Dropped words never stall the host, so padding drains even when the buffer is full
  always_comb begin
    cmd_ready_o = 1'b1;
    if (state_reg == tcad_pkg::TCAD_DATA && emit) begin
      // Back-pressure only for words that are really stored
      cmd_ready_o = wr_if.ready;
    end
  end
  assign take = cmd_valid_i && cmd_ready_o;

  // Only words with at least one valid lane are pushed into the buffer
  assign wr_if.data = cmd_data_i;
  assign wr_if.be = be_w;
  assign wr_if.first_seg = fs_reg;
  assign wr_if.last_seg = ls_reg;
  assign wr_if.buf_end = (idx_reg == (n_ext - 11'h001));
  assign wr_if.valid = (state_reg == tcad_pkg::TCAD_DATA) && cmd_valid_i && emit;

  // The receiver drains the buffer at its own pace
  assign rd_if.ready = pay_ready_i;

  // Sequencer: command A, command B, then every host data word of the buffer
  always_comb begin
    state_next = state_reg;
    irq_req_next = irq_req_reg;
    align_next = align_reg;
    off_next = off_reg;
    size_next = size_reg;
    fs_next = fs_reg;
    ls_next = ls_reg;
    idx_next = idx_reg;
    done_next = 1'b0;
    pad_next = 1'b0;
    case (state_reg)
      tcad_pkg::TCAD_CMD_A: begin
        if (take) begin
          // Reserved bits are not looked at
          irq_req_next = cmd_data_i[tcad_pkg::CMDA_IRQ_BIT]; // R1 R3
          align_next = cmd_data_i[tcad_pkg::CMDA_ALIGN_HI:tcad_pkg::CMDA_ALIGN_LO]; // R4
          off_next = cmd_data_i[tcad_pkg::CMDA_OFF_HI:tcad_pkg::CMDA_OFF_LO]; // R7
          fs_next = cmd_data_i[tcad_pkg::CMDA_FS_BIT]; // R10
          ls_next = cmd_data_i[tcad_pkg::CMDA_LS_BIT]; // R10
          size_next = cmd_data_i[tcad_pkg::CMDA_SIZE_HI:tcad_pkg::CMDA_SIZE_LO]; // R9
          state_next = tcad_pkg::TCAD_CMD_B;
        end
      end
      tcad_pkg::TCAD_CMD_B: begin
        if (take) begin
          // Command B carries nothing this block uses; only its arrival counts
          idx_next = tcad_pkg::IDX_RST;
          if (p_words == tcad_pkg::IDX_RST) begin
            // Empty buffer is complete as soon as its commands are in
            done_next = irq_req_reg; // R1
            state_next = tcad_pkg::TCAD_CMD_A;
          end else begin
            state_next = tcad_pkg::TCAD_DATA;
          end
        end
      end
      tcad_pkg::TCAD_DATA: begin
        if (take) begin
          // Leading skipped words and padding are taken here but never pushed
          pad_next = is_pad; // R6
          idx_next = idx_reg + 11'h001;
          if (last_word) begin
            done_next = irq_req_reg; // R1
            state_next = tcad_pkg::TCAD_CMD_A;
          end
        end
      end
      default: state_next = tcad_pkg::TCAD_CMD_A;
    endcase

    // Routing is looked at in the cycle that completes the buffer
    irq_next = done_next && irq_route_en_i; // R2
  end

  // Registers only; every decision is made in the blocks above
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= tcad_pkg::TCAD_CMD_A;
      irq_req_reg <= 1'b0;
      align_reg <= tcad_pkg::ALIGN_4;
      off_reg <= tcad_pkg::OFF_RST;
      size_reg <= tcad_pkg::SIZE_RST;
      fs_reg <= 1'b0;
      ls_reg <= 1'b0;
      idx_reg <= tcad_pkg::IDX_RST;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      pad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      irq_req_reg <= irq_req_next;
      align_reg <= align_next;
      off_reg <= off_next;
      size_reg <= size_next;
      fs_reg <= fs_next;
      ls_reg <= ls_next;
      idx_reg <= idx_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
      pad_reg <= pad_next;
    end
  end

  // A receiver stall holds the host instead of losing a word
  tcad_skid u_skid (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .wr_if(wr_if),
    .rd_if(rd_if)
  );

  // Payload side comes straight from the buffer's flops
  assign pay_data_o = rd_if.data;
  assign pay_be_o = rd_if.be;
  assign pay_first_seg_o = rd_if.first_seg;
  assign pay_last_seg_o = rd_if.last_seg;
  assign pay_buf_end_o = rd_if.buf_end;
  assign pay_valid_o = rd_if.valid;

  // The flag marks the last host word taken, not the buffer drained downstream
  assign buffer_loaded_flag_o = done_reg;
  assign buffer_loaded_irq_o = irq_reg;
  assign first_segment_bit_o = fs_reg;
  assign last_segment_bit_o = ls_reg;
  assign align_code_o = align_reg;
  assign start_offset_o = off_reg;
  assign byte_count_o = size_reg;
  assign pad_drop_o = pad_reg;
endmodule // tcad_decoder

// ---- dv/tcad_decoder_checker.sv ----
// Port checker for the command word A decoder.
// Assumes bind onto tcad_decoder, one clock.
module tcad_decoder_checker (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic pay_valid_o,
  input wire logic pay_ready_i,
  input wire logic [31:0] pay_data_o,
  input wire logic irq_route_en_i,
  input wire logic buffer_loaded_flag_o,
  input wire logic buffer_loaded_irq_o,
  input wire logic first_segment_bit_o,
  input wire logic [1:0] align_code_o,
  input wire logic [4:0] start_offset_o,
  input wire logic pad_drop_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire tk = cmd_valid_i & cmd_ready_o;
  property p_flag; buffer_loaded_flag_o |-> $past(tk) ##1 !buffer_loaded_flag_o; endproperty
  a_flag: assert property (p_flag) else $error("bad flag");
  property p_irq;
    buffer_loaded_irq_o == (buffer_loaded_flag_o && $past(irq_route_en_i));
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_algn; $changed(align_code_o) |-> align_code_o == $past(cmd_data_i[25:24]); endproperty
  a_algn: assert property (p_algn) else $error("bad align");
  property p_off;
    $changed(start_offset_o) |-> start_offset_o == $past(cmd_data_i[20:16]);
  endproperty
  a_off: assert property (p_off) else $error("bad offset");
  property p_seg;
    $changed(first_segment_bit_o) |-> $past(tk && cmd_data_i[13]) == first_segment_bit_o;
  endproperty
  a_seg: assert property (p_seg) else $error("bad segment");
  property p_pad; pad_drop_o |-> $past(tk) && !$rose(pay_valid_o); endproperty
  a_pad: assert property (p_pad) else $error("pad stored");
  property p_hold; pay_valid_o && !pay_ready_i |=> pay_valid_o && $stable(pay_data_o); endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_full; !cmd_ready_o |-> pay_valid_o; endproperty
  a_full: assert property (p_full) else $error("bad stall");
endmodule // tcad_decoder_checker

bind tcad_decoder tcad_decoder_checker i_chk (.clk_sys_i, .resetn_i, .cmd_data_i, .cmd_valid_i,
  .cmd_ready_o, .pay_valid_o, .pay_ready_i, .pay_data_o, .irq_route_en_i, .buffer_loaded_flag_o,
  .buffer_loaded_irq_o, .first_segment_bit_o, .align_code_o, .start_offset_o, .pad_drop_o);

// ---- dv/tcad_host_model.sv ----
// Host model: command A, zero command B, payload and pad words.
// Assumes a word is taken at a rising edge with valid and ready high.
module tcad_host_model (
  input wire logic clk_i,
  input wire logic rdy_i,
  output logic [31:0] dat_o,
  output logic vld_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    vld_o = 1'b0;
    dat_o = 32'h5a5a_5a5a;
  end
  // Ready only moves just after rising edges, so it is settled when read just after a falling one
  task automatic put(input logic [31:0] w);
    logic r;
    @(negedge clk_i);
    dat_o = w;
    vld_o = 1'b1;
    forever begin
      #1 r = rdy_i;
      @(posedge clk_i);
      if (r) break;
      @(negedge clk_i);
    end
  endtask
  // Released lines show the inverse; a second idle in a row inverts back to the stale word
  task automatic idle();
    @(negedge clk_i);
    vld_o = 1'b0;
    dat_o = ~dat_o;
  endtask
  task automatic send_buf(input logic [31:0] a, input int gap);
    int w;
    int m;
    w = (a[20:16] + a[10:0] + 3) / 4;
    m = (a[25:24] == 2'h1) ? 4 : (a[25:24] == 2'h2) ? 8 : 1;
    w = (w + m - 1) / m * m;
    put(a);
    put(32'h0);
    for (int i = 0; i < w; i++) begin
      put(32'ha5a5_0000 + i);
      repeat (gap) idle();
    end
    idle();
  endtask
endmodule // tcad_host_model

// ---- dv/tcad_decoder_tb_top.sv ----
// Testbench: host model feeds buffers, scenario tasks judge payload and pulses.
// Assumes package, interface, buffer and decoder are compiled first.
module tcad_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rdy = 1'b1;
  logic route = 1'b0;
  logic vld, crdy, fv, ir, pv, fs, ls, pe, pad, pfs, pls;
  logic [31:0] dat, pd;
  logic [3:0] pbe;
  logic [1:0] al;
  logic [4:0] so;
  logic [10:0] bc;
  logic [38:0] q[$];
  int err_total = 0;
  int num_checks = 0;
  int nf, ni, np;
  always #25 clk_sys_i = ~clk_sys_i;
  tcad_host_model i_host (.clk_i(clk_sys_i), .rdy_i(crdy), .dat_o(dat), .vld_o(vld));
  tcad_decoder i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cmd_data_i(dat),
    .cmd_valid_i(vld), .cmd_ready_o(crdy), .pay_data_o(pd), .pay_be_o(pbe),
    .pay_first_seg_o(pfs), .pay_last_seg_o(pls), .pay_buf_end_o(pe), .pay_valid_o(pv),
    .pay_ready_i(rdy), .irq_route_en_i(route), .buffer_loaded_flag_o(fv),
    .buffer_loaded_irq_o(ir), .first_segment_bit_o(fs), .last_segment_bit_o(ls),
    .align_code_o(al), .start_offset_o(so), .byte_count_o(bc), .pad_drop_o(pad));
  always @(posedge clk_sys_i) begin
    if (resetn_i && pv && rdy) q.push_back({pfs, pls, pd, pbe, pe});
    nf += (fv === 1'b1);
    ni += (ir === 1'b1);
    np += (pad === 1'b1);
  end
  task automatic chk(input string n, input logic [38:0] g, input logic [38:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic go(input logic [31:0] a, input int gap);
    q = {};
    nf = 0;
    ni = 0;
    np = 0;
    i_host.send_buf(a, gap);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic t_walk();
    @(negedge clk_sys_i) route = 1'b1;
    go(32'h8101_0006, 0);
    chk("align", al, 2'h1);
    chk("offset", so, 5'h01);
    chk("count", bc, 11'h006);
    chk("words", q.size(), 8'h2);
    chk("word0", q[0], {32'ha5a5_0000, 4'he, 1'b0});
    chk("word1", q[1], {32'ha5a5_0001, 4'h7, 1'b1});
    chk("flag", nf, 8'h1);
    chk("irq", ni, 8'h1);
    chk("pads", np, 8'h2);
  endtask
  task automatic t_skip();
    @(negedge clk_sys_i) route = 1'b0;
    go(32'h0209_3003, 1);
    chk("first", fs, 1'h1);
    chk("last", ls, 1'h1);
    chk("align", al, 2'h2);
    chk("words", q.size(), 8'h1);
    chk("word2", q[0], {2'h3, 32'ha5a5_0002, 4'he, 1'b1});
    chk("flag", nf, 8'h0);
    chk("pads", np, 8'h5);
  endtask
  task automatic t_rsvd();
    go(32'h8300_0005, 0);
    chk("align", al, 2'h3);
    chk("words", q.size(), 8'h2);
    chk("word1", q[1], {32'ha5a5_0001, 4'h1, 1'b1});
    chk("pads", np, 8'h0);
    chk("irq", ni, 8'h0);
    chk("flag", nf, 8'h1);
  endtask
  task automatic t_empty();
    @(negedge clk_sys_i) route = 1'b1;
    go(32'h8000_0000, 0);
    chk("words", q.size(), 8'h0);
    chk("flag", nf, 8'h1);
    chk("irq", ni, 8'h1);
    chk("pads", np, 8'h0);
  endtask
  task automatic t_stall();
    @(negedge clk_sys_i) rdy = 1'b0;
    fork
      go(32'h0000_0010, 0);
      begin
        repeat (12) @(posedge clk_sys_i);
        chk("stalled", crdy, 1'h0);
        chk("held", q.size(), 8'h0);
        @(negedge clk_sys_i) rdy = 1'b1;
      end
    join
    chk("words", q.size(), 8'h4);
    for (int i = 0; i < 4; i++) chk("word", q[i], {32'ha5a5_0000 + i, 4'hf, i == 3});
    chk("flag", nf, 8'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i) resetn_i = 1'b1;
    chk("ready", crdy, 1'h1);
    chk("valid", pv, 1'h0);
    t_walk();
    t_skip();
    t_rsvd();
    t_empty();
    t_stall();
    stop_test();
  end
  // Whole run needs under 150 cycles
  initial begin
    #(400 * 50);
    err_total++;
    stop_test();
  end
endmodule // tcad_decoder_tb_top
